// File: rtl/sli_pkg.sv
// shared constants, types and register map of the status lamp block
package sli_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_DIV = 1000;
  localparam int unsigned HOLD_MS = 500;
  localparam int unsigned PAUSE_S = 2;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / MS_DIV);
  localparam int unsigned PAUSE_CYC = PAUSE_S * CLK_HZ;
  localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / MS_DIV);
  localparam int CNT_W = 26;
  typedef logic [CNT_W-1:0] sli_cnt_t;
  localparam sli_cnt_t CNT_ZERO = 26'h0000000;
  localparam sli_cnt_t CNT_ONE = 26'h0000001;
  // ==========================================================
  // register map
  typedef logic [3:0] sli_addr_t;
  typedef logic [15:0] sli_word_t;
  localparam sli_addr_t A_CMD = 4'h0;
  localparam sli_addr_t A_STAT = 4'h1;
  localparam sli_addr_t A_HIST = 4'h2;
  localparam sli_addr_t A_ISTAT = 4'h3;
  localparam sli_addr_t A_IMASK = 4'h4;
  localparam sli_addr_t A_STATE = 4'h5;
  localparam sli_word_t WORD_ZERO = 16'h0000;
  localparam int CB_GIO_POS = 0;
  localparam int CB_GIO_NEG = 1;
  localparam int CB_CLR_HIST = 2;
  localparam int SB_HW_POS = 10;
  localparam int SB_HW_NEG = 11;
  localparam int SB_SW_POS = 12;
  localparam int SB_SW_NEG = 13;
  localparam int SB_POS_SEEN = 14;
  localparam int SB_NEG_SEEN = 15;
  localparam int ST_CODE_LSB = 4;
  localparam int EV_W = 4;
  typedef logic [EV_W-1:0] sli_ev_t;
  localparam sli_ev_t EV_NONE = 4'h0;
  localparam logic [1:0] LIM_EN_RST = 2'h3;
  localparam logic [1:0] LIM_OFF = 2'h0;
  // ==========================================================
  // fault codes and patterns
  typedef logic [3:0] sli_code_t;
  localparam sli_code_t FC_NONE = 4'h0;
  localparam sli_code_t FC_ONE = 4'h1;
  localparam sli_code_t FC_MIN = 4'h2;
  localparam sli_code_t FC_HW_POS = 4'h8;
  localparam sli_code_t FC_HW_NEG = 4'h9;
  localparam sli_code_t FC_SW_POS = 4'hA;
  localparam sli_code_t FC_SW_NEG = 4'hB;
  localparam logic [7:0] TRI_PAT = 8'h15;
  localparam logic [2:0] SLOT_ZERO = 3'h0;
  typedef enum logic [1:0] {PW_CAPT = 2'b00, PW_HOLD = 2'b01, PW_LIMF = 2'b10,
    PW_RUN = 2'b11} sli_pw_t;
  typedef enum logic [1:0] {FL_IDLE = 2'b00, FL_PAUSE = 2'b01, FL_ON = 2'b10,
    FL_OFF = 2'b11} sli_fl_t;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic enabled; logic en_in; logic faulted; logic wdog;
    logic boot; logic traj; sli_code_t code;
  } sli_drv_t;
  typedef struct packed {
    logic prog; logic prog_nolim; logic lim_pos; logic lim_neg;
    logic sw_pos; logic sw_neg;
  } sli_io_t;
  typedef struct packed {
    sli_addr_t addr; sli_word_t wdata; logic wr; logic rd;
  } sli_req_t;
  typedef struct packed {
    logic pwr_red; logic pwr_green; logic traj_red; logic traj_green;
    logic [1:0] link; logic [1:0] act;
  } sli_lamp_t;
  localparam sli_lamp_t LAMP_DARK = 8'h00;

  // last count of a cycle counter that runs from zero
  function automatic logic cnt_end(input sli_cnt_t c, input sli_cnt_t len);
    return c == len - CNT_ONE;
  endfunction
endpackage

// File: rtl/sli_blink.sv
// shared half-period tick, square blink and triple-flash pattern
`timescale 1ns/1ps
module sli_blink #(
  parameter sli_pkg::sli_cnt_t HALF_LEN = sli_pkg::sli_cnt_t'(sli_pkg::BLINK_CYC)
) (
  input logic mclk,
  input logic resetn,
  input logic ce,
  output logic tick,
  output logic blink,
  output logic triple
);
  import sli_pkg::*;

  sli_cnt_t cnt_q, cnt_d;
  logic [2:0] slot_q, slot_d;
  logic blink_q, blink_d;
  logic tick_d;

  // ==========================================================
  // one divider for all lamps so every pattern stays in phase
  always_comb begin
    tick_d = cnt_end(cnt_q, HALF_LEN);
    cnt_d = tick_d ? CNT_ZERO : cnt_q + CNT_ONE;
    blink_d = blink_q ^ tick_d;
    slot_d = slot_q + {2'h0, tick_d};
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= CNT_ZERO;
      slot_q <= SLOT_ZERO;
      blink_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      slot_q <= slot_d;
      blink_q <= blink_d;
    end
  end

  assign tick = tick_d && ce;
  assign blink = blink_q;
  assign triple = TRI_PAT[slot_q];
endmodule

// File: rtl/sli_flash.sv
// counted fault-code flasher with a dark pause before each burst
`timescale 1ns/1ps
module sli_flash #(
  parameter sli_pkg::sli_cnt_t PAUSE_LEN = sli_pkg::sli_cnt_t'(sli_pkg::PAUSE_CYC)
) (
  input logic mclk,
  input logic resetn,
  input logic ce,
  input logic en,
  input logic tick,
  input sli_pkg::sli_code_t code,
  output logic lamp
);
  import sli_pkg::*;

  sli_fl_t st_q, st_d;
  sli_cnt_t cnt_q, cnt_d;
  sli_code_t left_q, left_d, lat_q, lat_d, nfl_q, nfl_d;
  logic lamp_q;

  // ==========================================================
  // burst sequencer; code is latched per burst so a change never cuts one short
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    left_d = left_q;
    lat_d = lat_q;
    nfl_d = nfl_q;
    unique case (st_q)
      FL_IDLE: begin
        cnt_d = CNT_ZERO;
        if (en) st_d = FL_PAUSE;
      end
      FL_PAUSE: begin
        cnt_d = cnt_q + CNT_ONE;
        if (cnt_end(cnt_q, PAUSE_LEN)) begin
          cnt_d = CNT_ZERO;
          lat_d = code;
          left_d = code;
          nfl_d = FC_NONE;
          if (code >= FC_MIN) st_d = FL_OFF;
        end
      end
      FL_OFF: begin
        if (tick && left_q == FC_NONE) st_d = FL_PAUSE;
        else if (tick) begin
          st_d = FL_ON;
          left_d = left_q - FC_ONE;
          nfl_d = nfl_q + FC_ONE;
        end
      end
      FL_ON: if (tick) st_d = FL_OFF;
    endcase
    if (!en) st_d = FL_IDLE;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= FL_IDLE;
      cnt_q <= CNT_ZERO;
      left_q <= FC_NONE;
      lat_q <= FC_NONE;
      nfl_q <= FC_NONE;
      lamp_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      left_q <= left_d;
      lat_q <= lat_d;
      nfl_q <= nfl_d;
      lamp_q <= (st_d == FL_ON);
    end
  end

  assign lamp = lamp_q;

  property p_burst_count;
    @(posedge mclk) disable iff (!resetn)
    st_q == FL_OFF && tick && left_q == FC_NONE && en && ce |-> nfl_q == lat_q;
  endproperty
  a_burst_count: assert property (p_burst_count) else $error("flash count differs");

  // the pause must run its full count, one step per enabled cycle, with the lamp dark
  property p_pause_dark;
    @(posedge mclk) disable iff (!resetn)
    st_q == FL_PAUSE && en && ce && !cnt_end(cnt_q, PAUSE_LEN) |=>
      st_q == FL_PAUSE && !lamp_q && cnt_q == $past(cnt_q) + CNT_ONE;
  endproperty
  a_pause_dark: assert property (p_pause_dark) else $error("lamp lit during pause");
endmodule

// File: rtl/sli_top.sv
// status lamp controller: power-up sequence, lamp patterns, fault bits, regs
`timescale 1ns/1ps
module sli_top #(
  parameter sli_pkg::sli_cnt_t HOLD_LEN = sli_pkg::sli_cnt_t'(sli_pkg::HOLD_CYC),
  parameter sli_pkg::sli_cnt_t PAUSE_LEN = sli_pkg::sli_cnt_t'(sli_pkg::PAUSE_CYC),
  parameter sli_pkg::sli_cnt_t HALF_LEN = sli_pkg::sli_cnt_t'(sli_pkg::BLINK_CYC)
) (
  input logic mclk,
  input logic resetn,
  input logic ce,
  input sli_pkg::sli_drv_t drv,
  input sli_pkg::sli_io_t io,
  input logic [1:0] link_up,
  input logic [1:0] traffic,
  input sli_pkg::sli_req_t bus,
  output sli_pkg::sli_word_t rdata,
  output sli_pkg::sli_lamp_t lamps,
  output logic irq
);
  import sli_pkg::*;

  // ==========================================================
  // bus decode
  logic wr_cmd;
  logic gio_pos;
  logic gio_neg;
  logic clr_hist;
  logic rd_ist;
  logic wr_mask;

  // command writes act once; the bits are not stored, only their clearing of lim_en_q, seen_q and hist_q stays
  assign wr_cmd = bus.wr && (bus.addr == A_CMD);
  assign gio_pos = wr_cmd && bus.wdata[CB_GIO_POS];
  assign gio_neg = wr_cmd && bus.wdata[CB_GIO_NEG];
  assign clr_hist = wr_cmd && bus.wdata[CB_CLR_HIST];
  assign rd_ist = bus.rd && (bus.addr == A_ISTAT);
  assign wr_mask = bus.wr && (bus.addr == A_IMASK);

  // ==========================================================
  // travel limits
  logic [1:0] lim_en_q, lim_en_d;
  logic [1:0] en_eff;
  logic hw_pos_act;
  logic hw_neg_act;
  logic sw_pos_act;
  logic sw_neg_act;
  logic lim_flt;

  // a general-I/O command wins over the old enable in the same cycle
  assign en_eff = lim_en_q & ~{gio_neg, gio_pos};
  // hardware limit inputs are active low, so an open connector reads as a hit
  assign hw_pos_act = en_eff[0] && !io.lim_pos;
  assign hw_neg_act = en_eff[1] && !io.lim_neg;
  assign sw_pos_act = en_eff[0] && io.sw_pos;
  assign sw_neg_act = en_eff[1] && io.sw_neg;
  assign lim_flt = hw_pos_act || hw_neg_act || sw_pos_act || sw_neg_act;

  // ==========================================================
  // power-up sequence
  sli_pw_t pw_q, pw_d;
  sli_cnt_t hold_q, hold_d;

  // program straps are sampled one edge after reset, never under reset
  always_comb begin
    pw_d = pw_q;
    hold_d = hold_q;
    lim_en_d = en_eff;
    unique case (pw_q)
      PW_CAPT: begin
        if (io.prog_nolim) lim_en_d = LIM_OFF;
        if (!io.prog && !io.lim_pos && !io.lim_neg) pw_d = PW_LIMF;
        else pw_d = PW_HOLD;
      end
      PW_HOLD: begin
        hold_d = hold_q + CNT_ONE;
        if (cnt_end(hold_q, HOLD_LEN)) pw_d = PW_RUN;
      end
      PW_LIMF: begin
        if (!lim_flt) pw_d = PW_RUN;
      end
      PW_RUN: begin
        pw_d = PW_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pw_q <= PW_CAPT;
      hold_q <= CNT_ZERO;
      lim_en_q <= LIM_EN_RST;
    end else if (ce) begin
      pw_q <= pw_d;
      hold_q <= hold_d;
      lim_en_q <= lim_en_d;
    end
  end

  // ==========================================================
  // fault status and history
  logic [1:0] seen_q, seen_d;
  sli_word_t hist_q, hist_d;
  sli_word_t stat_w;
  sli_code_t act_code;
  logic fault_any;

  // one history bit per flash code; codes below the first used one map to none
  function automatic sli_word_t code_bit(input sli_code_t c);
    code_bit = WORD_ZERO;
    if (c >= FC_MIN) code_bit[c] = 1'b1;
  endfunction

  assign fault_any = drv.faulted || lim_flt;

  // drive faults take precedence over limits when picking the flash code
  always_comb begin
    act_code = FC_NONE;
    if (drv.faulted) act_code = drv.code;
    else if (hw_pos_act) act_code = FC_HW_POS;
    else if (hw_neg_act) act_code = FC_HW_NEG;
    else if (sw_pos_act) act_code = FC_SW_POS;
    else if (sw_neg_act) act_code = FC_SW_NEG;
  end

  // live status word
  always_comb begin
    stat_w = WORD_ZERO;
    stat_w[SB_HW_POS] = hw_pos_act;
    stat_w[SB_HW_NEG] = hw_neg_act;
    stat_w[SB_SW_POS] = sw_pos_act;
    stat_w[SB_SW_NEG] = sw_neg_act;
    stat_w[SB_POS_SEEN] = seen_q[0];
    stat_w[SB_NEG_SEEN] = seen_q[1];
  end

  // a limit still active at clear time sets its bit again: set beats clear
  always_comb begin
    seen_d[0] = (seen_q[0] && !gio_pos && !clr_hist) || hw_pos_act || sw_pos_act;
    seen_d[1] = (seen_q[1] && !gio_neg && !clr_hist) || hw_neg_act || sw_neg_act;
    hist_d = clr_hist ? WORD_ZERO : hist_q;
    if (fault_any) hist_d = hist_d | code_bit(act_code);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seen_q <= LIM_OFF;
      hist_q <= WORD_ZERO;
    end else if (ce) begin
      seen_q <= seen_d;
      hist_q <= hist_d;
    end
  end

  // ==========================================================
  // lamp patterns
  logic tick;
  logic blink;
  logic triple;
  logic flash;
  logic run_ok;
  logic red_solid;
  logic traj_cond;
  sli_lamp_t lamp_d, lamp_q;

  assign run_ok = (pw_q == PW_RUN) && !drv.boot && !drv.wdog;
  assign red_solid = run_ok && (fault_any || !drv.en_in);
  assign traj_cond = run_ok && !red_solid && drv.enabled && drv.traj;

  sli_blink #(
    .HALF_LEN(HALF_LEN)
  ) u_blink (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .tick(tick),
    .blink(blink),
    .triple(triple)
  );

  // the flasher restarts with a full pause whenever solid red begins
  sli_flash #(
    .PAUSE_LEN(PAUSE_LEN)
  ) u_flash (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .en(red_solid),
    .tick(tick),
    .code(act_code),
    .lamp(flash)
  );

  // power lamp priority: boot loader, watchdog, fault, enabled, idle
  always_comb begin
    lamp_d = LAMP_DARK;
    lamp_d.link = link_up;
    lamp_d.act = traffic & {2{blink}};
    unique case (pw_q)
      PW_CAPT, PW_HOLD, PW_LIMF: begin
        lamp_d.pwr_red = 1'b1;
      end
      PW_RUN: begin
        if (drv.boot) begin
          lamp_d.pwr_red = blink;
          lamp_d.pwr_green = !blink;
        end else if (drv.wdog) begin
          lamp_d.pwr_red = triple;
        end else if (red_solid) begin
          lamp_d.pwr_red = 1'b1;
          lamp_d.traj_red = flash;
        end else if (drv.enabled) begin
          lamp_d.pwr_green = 1'b1;
          lamp_d.traj_green = drv.traj;
        end else begin
          lamp_d.pwr_green = blink;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lamp_q <= LAMP_DARK;
    end else if (ce) begin
      lamp_q <= lamp_d;
    end
  end

  assign lamps = lamp_q;

  // ==========================================================
  // interrupts and register reads
  sli_ev_t prev_q, prev_d;
  sli_ev_t ev;
  sli_ev_t ist_q, ist_d;
  sli_ev_t mask_q, mask_d;
  sli_word_t rdata_q, rdata_d;
  logic irq_q, irq_d;

  // rising edges of fault, watchdog, limit and ready; set beats read-clear
  always_comb begin
    prev_d = {pw_q == PW_RUN, lim_flt, drv.wdog, red_solid};
    ev = prev_d & ~prev_q;
    ist_d = (rd_ist ? EV_NONE : ist_q) | ev;
    mask_d = wr_mask ? bus.wdata[EV_W-1:0] : mask_q;
    irq_d = |(ist_d & mask_d);
    rdata_d = WORD_ZERO;
    if (bus.rd) begin
      unique case (bus.addr)
        A_CMD: rdata_d[1:0] = lim_en_q;
        A_STAT: rdata_d = stat_w;
        A_HIST: rdata_d = hist_q;
        A_ISTAT: rdata_d[EV_W-1:0] = ist_q;
        A_IMASK: rdata_d[EV_W-1:0] = mask_q;
        A_STATE: rdata_d = {8'h00, act_code, 2'h0, pw_q};
        default: rdata_d = WORD_ZERO;
      endcase
    end
  end

  // accesses made while ce is low are lost, like every other input then
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= EV_NONE;
      ist_q <= EV_NONE;
      mask_q <= EV_NONE;
      rdata_q <= WORD_ZERO;
      irq_q <= 1'b0;
    end else if (ce) begin
      prev_q <= prev_d;
      ist_q <= ist_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_drive_on;
    run_ok && !red_solid && drv.enabled && ce |=> lamps.pwr_green && !lamps.pwr_red;
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("power lamp not green");

  property p_wdog;
    pw_q == PW_RUN && !drv.boot && drv.wdog && ce |=>
      lamps.pwr_red == $past(triple) && !lamps.pwr_green;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog pattern wrong");

  property p_red;
    red_solid && ce |=> lamps.pwr_red && !lamps.pwr_green;
  endproperty
  a_red: assert property (p_red) else $error("power lamp not steady red");

  property p_boot;
    pw_q == PW_RUN && drv.boot && ce |=> lamps.pwr_red != lamps.pwr_green;
  endproperty
  a_boot: assert property (p_boot) else $error("boot pattern not alternating");

  property p_limf;
    pw_q == PW_LIMF && ce |=> lamps.pwr_red && !lamps.traj_red && !lamps.traj_green;
  endproperty
  a_limf: assert property (p_limf) else $error("limit fault lamps wrong");

  property p_hold;
    pw_q == PW_HOLD && ce |=>
      lamps.pwr_red && !lamps.pwr_green && !lamps.traj_red && !lamps.traj_green;
  endproperty
  a_hold: assert property (p_hold) else $error("hold lamps wrong");

  property p_nolim;
    // sampled resetn keeps the release edge out: the flops are still in reset there
    resetn && pw_q == PW_CAPT && io.prog_nolim && ce |=>
      pw_q == PW_HOLD && lim_en_q == LIM_OFF;
  endproperty
  a_nolim: assert property (p_nolim) else $error("limits not disabled");

  property p_link;
    resetn && ce |=> lamps.link == $past(link_up);
  endproperty
  a_link: assert property (p_link) else $error("link lamp mismatch");

  property p_act;
    ce && traffic == 2'h0 |=> lamps.act == 2'h0;
  endproperty
  a_act: assert property (p_act) else $error("activity lamp lit idle");

  property p_traj;
    ce |=> lamps.traj_green == $past(traj_cond);
  endproperty
  a_traj: assert property (p_traj) else $error("trajectory lamp wrong");

  property p_gio;
    ce && gio_pos |=> !lim_en_q[0] && !seen_q[0] && !stat_w[SB_HW_POS];
  endproperty
  a_gio: assert property (p_gio) else $error("limit bits not cleared");

  property p_clr;
    ce && clr_hist && !fault_any |=> hist_q == WORD_ZERO;
  endproperty
  a_clr: assert property (p_clr) else $error("history not cleared");
endmodule

// File: bench/sli_lamp_watch.sv
// lamp watcher: counts flashes, bursts and dark gaps as an operator would
`timescale 1ns/1ps
module sli_lamp_watch (
  input wire logic mclk,
  input wire sli_pkg::sli_lamp_t lamps,
  output int flashes,
  output int burst,
  output int gap,
  output int red_rises,
  output int green_rises
);
  import sli_pkg::*;
  int dark;
  logic tr_q = 1'b0;
  logic pr_q = 1'b0;
  logic pg_q = 1'b0;
  // ==========================================================
  // edge counting
  // a dark stretch longer than any flash gap closes a burst
  always @(posedge mclk) begin
    tr_q <= lamps.traj_red;
    pr_q <= lamps.pwr_red;
    pg_q <= lamps.pwr_green;
    if (lamps.pwr_red && !pr_q) red_rises <= red_rises + 1;
    if (lamps.pwr_green && !pg_q) green_rises <= green_rises + 1;
    if (lamps.traj_red && !tr_q) begin
      if (dark > 12) begin
        burst <= flashes;
        gap <= dark;
        flashes <= 1;
      end else flashes <= flashes + 1;
      dark <= 0;
    end else if (!lamps.traj_red) dark <= dark + 1;
  end
endmodule

// File: bench/tb_status_led_indicator.sv
// self-checking bench for the status lamp controller
`timescale 1ns/1ps
module tb_status_led_indicator;
  import sli_pkg::*;
  // short counts keep the run brief; every expectation follows them
  localparam sli_cnt_t HOLD = 26'h0000014;
  localparam sli_cnt_t PAUSE = 26'h0000028;
  localparam sli_cnt_t HALF = 26'h0000004;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  sli_drv_t drv = '0;
  sli_io_t io = '0;
  logic [1:0] link_up = 2'h0;
  logic [1:0] traffic = 2'h0;
  sli_req_t bus = '0;
  sli_word_t rdata;
  sli_lamp_t lamps;
  logic irq;
  int fail_count = 0;
  int checks_done = 0;
  int flashes, burst, gap, red_rises, green_rises;
  int seen[$];
  int r0, g0, c, m;
  sli_word_t v, hist_exp;
  // ==========================================================
  // clock and instances
  initial forever #20 mclk = ~mclk;
  sli_top #(.HOLD_LEN(HOLD), .PAUSE_LEN(PAUSE), .HALF_LEN(HALF)) dut_u (.mclk(mclk),
    .resetn(resetn), .ce(ce), .drv(drv), .io(io), .link_up(link_up), .traffic(traffic),
    .bus(bus), .rdata(rdata), .lamps(lamps), .irq(irq));
  sli_lamp_watch eye_u (.mclk(mclk), .lamps(lamps), .flashes(flashes), .burst(burst),
    .gap(gap), .red_rises(red_rises), .green_rises(green_rises));
  // ==========================================================
  // helpers
  task automatic stop_test();
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input sli_word_t exp, input sli_word_t got);
    checks_done++;
    if (exp !== got) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input sli_addr_t a, input sli_word_t d);
    @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus.wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input sli_addr_t a, output sli_word_t d);
    @(posedge mclk) bus <= '{a, WORD_ZERO, 1'b0, 1'b1};
    @(posedge mclk) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rst(input sli_io_t s);
    @(posedge mclk) resetn <= 1'b0;
    io <= s;
    drv <= 10'h100;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
  endtask
  task automatic wait_burst(input int n);
    int k;
    for (k = 0; k < 600 && burst != n; k++) @(posedge mclk);
    if (k == 600) begin
      fail_count++;
      stop_test();
    end
  endtask
  // reference: flash count from drive fault first, then limits by priority
  function automatic int model_code(input sli_drv_t d, input sli_io_t s);
    if (d.faulted) return d.code;
    if (!s.lim_pos) return 8;
    if (!s.lim_neg) return 9;
    if (s.sw_pos) return 10;
    if (s.sw_neg) return 11;
    return 0;
  endfunction
  // hang guard, far beyond the longest sequence
  initial begin
    #3000000;
    fail_count++;
    stop_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(24));
    rst(6'h0C);
    cyc(10);
    chk("hold lamps", 16'h0004, {lamps.pwr_red, lamps.traj_red, lamps.traj_green});
    cyc(30);
    g0 = green_rises;
    cyc(40);
    chk("idle blink", 16'h0005, 16'(green_rises - g0));
    rd(A_STATE, v);
    chk("run state", 16'h0003, v & 16'h0003);
    @(posedge mclk) drv.enabled <= 1'b1;
    drv.traj <= 1'b1;
    cyc(3);
    chk("on lamps", 16'h0005, {lamps.pwr_red, lamps.pwr_green, lamps.traj_red, lamps.traj_green});
    wr(A_IMASK, 16'h000F);
    for (c = 2; c <= 11; c++) begin
      @(posedge mclk) drv <= 10'h100;
      io <= 6'h0C;
      cyc(20);
      @(posedge mclk);
      if (c < 8) drv <= {6'h18, 4'(c)};
      else io <= (c == 8) ? 6'h04 : (c == 9) ? 6'h08 : (c == 10) ? 6'h0E : 6'h0D;
      cyc(1);
      m = model_code(drv, io);
      seen.push_back(m);
      wait_burst(m);
      chk("pause", 16'h0001, 16'(gap >= PAUSE && gap <= PAUSE + 2 * HALF));
      #1 chk("solid red", 16'h0002, {lamps.pwr_red, lamps.pwr_green});
      chk("irq", 16'h0001, 16'(irq));
    end
    @(posedge mclk) drv <= 10'h100;
    io <= 6'h0C;
    cyc(20);
    rd(A_ISTAT, v);
    chk("events", 16'h0009, v & 16'h0009);
    rd(A_ISTAT, v);
    chk("events cleared", 16'h0000, v);
    chk("irq low", 16'h0000, 16'(irq));
    hist_exp = WORD_ZERO;
    foreach (seen[i]) hist_exp[seen[i]] = 1'b1;
    rd(A_HIST, v);
    chk("history", hist_exp, v);
    rd(A_STAT, v);
    chk("latched", 16'hC000, v);
    wr(A_CMD, 16'h0003);
    rd(A_CMD, v);
    chk("limit enables", 16'h0000, v & 16'h0003);
    @(posedge mclk) io <= 6'h00;
    cyc(6);
    chk("limits ignored", 16'h0000, 16'(lamps.pwr_red));
    rd(A_STAT, v);
    chk("status cleared", 16'h0000, v);
    // history clear comes after the general-I/O command so that one alone clears the latches
    wr(A_CMD, 16'h0004);
    rd(A_HIST, v);
    chk("history cleared", 16'h0000, v);
    @(posedge mclk) drv <= 10'h000;
    cyc(3);
    chk("no enable", 16'h0001, 16'(lamps.pwr_red));
    @(posedge mclk) drv <= 10'h140;
    cyc(8);
    r0 = red_rises;
    cyc(64);
    chk("triple", 16'h0006, 16'(red_rises - r0));
    rd(A_ISTAT, v);
    chk("watchdog event", 16'h0002, v & 16'h0002);
    @(posedge mclk) drv <= 10'h120;
    cyc(8);
    r0 = red_rises;
    g0 = green_rises;
    cyc(32);
    chk("alt red", 16'h0004, 16'(red_rises - r0));
    chk("alt green", 16'h0004, 16'(green_rises - g0));
    // with ce low the alternating lamps must stand still across a blink half period
    @(posedge mclk) ce <= 1'b0;
    cyc(2);
    v = {8'h00, lamps};
    cyc(6);
    chk("frozen lamps", v, {8'h00, lamps});
    @(posedge mclk) ce <= 1'b1;
    repeat (20) begin
      @(posedge mclk) link_up <= 2'($urandom);
      traffic <= 2'($urandom);
      cyc(2);
      chk("link", {14'h0000, link_up}, {14'h0000, lamps.link});
      chk("quiet", 16'h0000, {14'h0000, lamps.act & ~traffic});
    end
    @(posedge mclk) traffic <= 2'h3;
    cyc(3);
    v = {14'h0000, ~lamps.act};
    cyc(4);
    chk("activity blink", v, {14'h0000, lamps.act});
    wr(4'hF, 16'hFFFF);
    rd(4'hF, v);
    chk("unmapped", 16'h0000, v);
    rd(A_IMASK, v);
    chk("mask kept", 16'h000F, v);
    rst(6'h00);
    cyc(30);
    chk("limit fault", 16'h0004, {lamps.pwr_red, lamps.traj_red, lamps.traj_green});
    rd(A_STATE, v);
    chk("limit state", 16'h0002, v & 16'h0003);
    rd(A_STAT, v);
    chk("boot limits", 16'hCC00, v & 16'hCC00);
    rst(6'h30);
    cyc(10);
    chk("nolim hold", 16'h0004, {lamps.pwr_red, lamps.traj_red, lamps.traj_green});
    cyc(30);
    g0 = green_rises;
    cyc(40);
    chk("nolim blink", 16'h0005, 16'(green_rises - g0));
    stop_test();
  end
endmodule
